//--- rtl/rsp_consts.svh
`ifndef RSP_CONSTS_SVH
`define RSP_CONSTS_SVH

`define RSP_CLK_MHZ        200
`define RSP_RST_HOLD_MS    200
`define RSP_PB_MIN_NS      1000
`define RSP_CE_HOLD_US     100
`define RSP_RST_HOLD_CYC   (`RSP_RST_HOLD_MS * 1000 * `RSP_CLK_MHZ)
`define RSP_PB_MIN_CYC     ((`RSP_PB_MIN_NS * `RSP_CLK_MHZ + 999) / 1000 + 1)
`define RSP_CE_HOLD_CYC    (`RSP_CE_HOLD_US * `RSP_CLK_MHZ)
`define RSP_CNT_W          26
`define RSP_SMALL_W        16
`define RSP_DATA_W         8

`endif

//--- rtl/rsp_pkg.sv
package rsp_pkg;
  typedef enum logic [1:0] {
    RSP_ST_RUN  = 2'b00,
    RSP_ST_FAIL = 2'b01,
    RSP_ST_HOLD = 2'b10
  } rsp_rst_state_t;

  typedef struct packed {
    logic       pwr_fail;
    logic       periodic;
    logic       alarm;
  } rsp_events_t;
endpackage

//--- rtl/rsp_sync2.sv
module rsp_sync2 (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Asynchronous level and its synchronised copy
  input  wire logic i_async,
  input  wire logic i_rst_val,
  output logic      o_sync
);
  logic meta_q;

  // Two-stage synchroniser, first stage read only by second
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_q <= i_rst_val;
      o_sync <= i_rst_val;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

//--- rtl/rsp_supervisor.sv
`include "rsp_consts.svh"

module rsp_supervisor #(
  parameter int unsigned RST_HOLD_CYC = `RSP_RST_HOLD_CYC,
  parameter int unsigned CE_HOLD_CYC  = `RSP_CE_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_sys_rst,
  // Supply monitor and interrupt sources
  input  wire logic                       i_pwr_fail,
  input  wire rsp_pkg::rsp_events_t       i_events,
  // Interrupt pin, open drain
  output logic                            o_int_n_o,
  output logic                            o_int_n_oe_n,
  // Processor reset pin, open drain with push-button sense
  input  wire logic                       i_rst_n_i,
  output logic                            o_rst_n_o,
  output logic                            o_rst_n_oe_n,
  // Host bus
  input  wire logic                       i_cs_n,
  input  wire logic                       i_oe_n,
  input  wire logic [`RSP_DATA_W-1:0]     i_rd_data,
  input  wire logic [`RSP_DATA_W-1:0]     i_data_lines_i,
  output logic      [`RSP_DATA_W-1:0]     o_data_lines_o,
  output logic      [`RSP_DATA_W-1:0]     o_data_lines_oe_n,
  output logic      [`RSP_DATA_W-1:0]     o_wr_data,
  // Chip-enable gate
  input  wire logic                       i_enable_gate_in_n,
  output logic                            o_enable_gate_out_n
);
  // Sequencer state and counters
  rsp_pkg::rsp_rst_state_t  state_q;
  logic [`RSP_CNT_W-1:0]    hold_cnt_q;
  logic [`RSP_SMALL_W-1:0]  pb_cnt_q;
  logic [`RSP_SMALL_W-1:0]  ce_cnt_q;
  logic                     pb_long_q;
  logic                     ce_gate_q;

  // Synchronised pin levels
  logic                     pf_s;
  logic                     pin_s;
  logic                     cs_s;
  logic                     oe_s;
  logic                     enable_gate_in_n_s;
  logic [4:0]               sync_in;
  logic [4:0]               sync_out;

  // Decoded conditions
  logic                     in_run;
  logic                     hold_done;
  logic                     pb_min_hit;
  logic                     ce_expired;
  logic                     int_req;
  logic                     rd_active;
  logic                     pb_release;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers, one each for i_pwr_fail, i_rst_n_i, i_cs_n, i_oe_n and i_enable_gate_in_n
  assign sync_in = {i_pwr_fail, i_rst_n_i, i_cs_n, i_oe_n, i_enable_gate_in_n};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      rsp_sync2 u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (sync_in[g]),
        .i_rst_val (1'b1),
        .o_sync    (sync_out[g])
      );
    end
  endgenerate

  assign pf_s   = sync_out[4];
  assign pin_s  = sync_out[3];
  assign cs_s   = sync_out[2];
  assign oe_s   = sync_out[1];
  assign enable_gate_in_n_s = sync_out[0];

  ////////////////////////////////////////////////////////////////////////
  // Push-button: measure external low time while we release the pin
  assign in_run     = (state_q == rsp_pkg::RSP_ST_RUN);
  assign pb_min_hit = (pb_cnt_q >= `RSP_SMALL_W'(`RSP_PB_MIN_CYC));

  // Low-time counter, saturates so a long press cannot wrap
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pb_cnt_q <= '0;
    end else if (in_run && !pin_s && !pb_min_hit) begin
      pb_cnt_q <= pb_cnt_q + 1'b1;
    end else if (!(in_run && !pin_s)) begin
      pb_cnt_q <= '0;
    end
  end

  // Long-press flag, dropped once the pin is high or we pull it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pb_long_q <= 1'b0;
    end else if (in_run && !pin_s) begin
      if (pb_min_hit) begin
        pb_long_q <= 1'b1;
      end
    end else begin
      pb_long_q <= 1'b0;
    end
  end

  assign pb_release = in_run && pin_s && pb_long_q;

  ////////////////////////////////////////////////////////////////////////
  // Reset sequencer
  assign hold_done = (hold_cnt_q >= `RSP_CNT_W'(RST_HOLD_CYC - 1));

  // State: supply loss beats everything, push-button only from run
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= rsp_pkg::RSP_ST_FAIL;
    end else if (pf_s) begin
      state_q <= rsp_pkg::RSP_ST_FAIL;
    end else begin
      case (state_q)
        rsp_pkg::RSP_ST_RUN: begin
          if (pb_release) begin
            state_q <= rsp_pkg::RSP_ST_HOLD;
          end
        end
        rsp_pkg::RSP_ST_FAIL: begin
          state_q <= rsp_pkg::RSP_ST_HOLD;
        end
        rsp_pkg::RSP_ST_HOLD: begin
          if (hold_done) begin
            state_q <= rsp_pkg::RSP_ST_RUN;
          end
        end
        default: begin
          state_q <= rsp_pkg::RSP_ST_FAIL;
        end
      endcase
    end
  end

  // Hold timer counts only in hold, restarts from zero on every entry
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hold_cnt_q <= '0;
    end else if (pf_s || state_q != rsp_pkg::RSP_ST_HOLD) begin
      hold_cnt_q <= '0;
    end else if (!hold_done) begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end

  // Reset pin pulled low outside run state or while pf_s is high, released otherwise
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rst_n_oe_n <= 1'b0;
    end else begin
      o_rst_n_oe_n <= (state_q == rsp_pkg::RSP_ST_RUN) && !pf_s;
    end
  end
  assign o_rst_n_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt: open drain, pull low on any event
  assign int_req = pf_s || i_events.pwr_fail || i_events.periodic
                   || i_events.alarm;

  // Registered pin enable, low while any source is pending
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_int_n_oe_n <= 1'b1;
    end else begin
      o_int_n_oe_n <= !int_req;
    end
  end

  // Pin only ever pulled low, the pull-up gives the high level
  assign o_int_n_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Host read data path
  assign rd_active = !cs_s && !oe_s;

  // Bus enables one cycle behind the synchronised strobes, data registered every cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_data_lines_o    <= '0;
      o_data_lines_oe_n <= '1;
      o_wr_data         <= '0;
    end else begin
      o_data_lines_o    <= i_rd_data;
      o_data_lines_oe_n <= {`RSP_DATA_W{!rd_active}};
      o_wr_data         <= i_data_lines_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Chip-enable gate with bounded hold on power fail
  assign ce_expired = (ce_cnt_q >= `RSP_SMALL_W'(CE_HOLD_CYC - 1));

  // Gate flop: input high clears, good supply sets, a fail is timed
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ce_gate_q <= 1'b0;
      ce_cnt_q  <= '0;
    end else if (enable_gate_in_n_s) begin
      ce_gate_q <= 1'b0;
      ce_cnt_q  <= '0;
    end else if (!pf_s) begin
      ce_gate_q <= 1'b1;
      ce_cnt_q  <= '0;
    end else if (ce_gate_q) begin
      if (ce_expired) begin
        ce_gate_q <= 1'b0;
      end else begin
        ce_cnt_q <= ce_cnt_q + 1'b1;
      end
    end
  end
  assign o_enable_gate_out_n = !ce_gate_q;
endmodule

//--- verification/rsp_props.sv
`include "rsp_consts.svh"
module rsp_props #(
  parameter int unsigned RST_HOLD_CYC = 50,
  parameter int unsigned CE_HOLD_CYC  = 20
) (
  input wire logic                   i_clk, i_sys_rst, i_pwr_fail, i_cs_n, i_oe_n,
  input wire rsp_pkg::rsp_events_t   i_events,
  input wire logic                   o_int_n_o, o_int_n_oe_n, o_rst_n_o, o_rst_n_oe_n,
  input wire logic [`RSP_DATA_W-1:0] o_data_lines_oe_n,
  input wire logic                   i_enable_gate_in_n, o_enable_gate_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RL = RST_HOLD_CYC + 20;
  localparam int CL = CE_HOLD_CYC + 10;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  int unsigned low_cnt_q;
  // Cycles the reset pin has been pulled with the supply good
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || o_rst_n_oe_n || i_pwr_fail) low_cnt_q <= 0;
    else low_cnt_q <= low_cnt_q + 1;
  end
  // Settled inputs
  sequence s_pf; i_pwr_fail [*3]; endsequence
  sequence s_rd; (!i_cs_n && !i_oe_n) [*4]; endsequence
  sequence s_idle; (i_cs_n || i_oe_n) [*4]; endsequence
  property p_int_set; (|i_events) |=> !o_int_n_oe_n; endproperty
  property p_int_od; o_int_n_o == 1'b0; endproperty
  property p_rst_pf; s_pf |=> !o_rst_n_oe_n; endproperty
  property p_rst_rel; $fell(i_pwr_fail) |=> !o_rst_n_oe_n [*8] ##[1:RL] o_rst_n_oe_n; endproperty
  property p_rst_len; $rose(o_rst_n_oe_n) |-> low_cnt_q >= RST_HOLD_CYC; endproperty
  property p_rst_od; o_rst_n_o == 1'b0; endproperty
  property p_rd; s_rd |=> o_data_lines_oe_n == 8'h00; endproperty
  property p_rd_off; s_idle |=> &o_data_lines_oe_n; endproperty
  property p_gate; i_enable_gate_in_n [*4] |=> o_enable_gate_out_n; endproperty
  property p_gate_pf; $rose(i_pwr_fail) |-> ##[1:CL] o_enable_gate_out_n; endproperty
  a_int_set: assert property (p_int_set) else $error("int not pulled");
  a_int_od: assert property (p_int_od) else $error("int drives high");
  a_rst_pf: assert property (p_rst_pf) else $error("reset not pulled");
  a_rst_rel: assert property (p_rst_rel) else $error("reset hold wrong");
  a_rst_len: assert property (p_rst_len) else $error("reset hold short");
  a_rst_od: assert property (p_rst_od) else $error("reset drives high");
  a_rd: assert property (p_rd) else $error("read not driven");
  a_rd_off: assert property (p_rd_off) else $error("bus driven idle");
  a_gate: assert property (p_gate) else $error("gate low idle");
  a_gate_pf: assert property (p_gate_pf) else $error("gate held long");
endmodule
bind rsp_supervisor rsp_props #(.RST_HOLD_CYC(RST_HOLD_CYC), .CE_HOLD_CYC(CE_HOLD_CYC)) u_props (.*);

//--- verification/rsp_host_model.sv
module rsp_host_model (
  input  wire logic       i_clk, i_host_en, i_btn, i_int_o, i_int_oe_n, i_rst_oe_n,
  input  wire logic [7:0] i_dev_d, i_dev_oe_n, i_host_d,
  output logic [7:0]      o_bus,
  output logic            o_int_pin, o_rst_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;
  logic [7:0] drv;
  // Released bus bits show the inverse of their last driven level
  always_comb begin
    drv   = i_host_en ? 8'hFF : ~i_dev_oe_n;
    o_bus = i_host_en ? i_host_d : ~last_q;
    o_bus = (~i_dev_oe_n & i_dev_d) | (i_dev_oe_n & o_bus);
  end
  // Remember only levels that someone actually drove
  always_ff @(posedge i_clk) begin
    last_q <= (drv & o_bus) | (~drv & last_q);
  end
  // Pull-ups on both open-drain pins, button pulls reset low
  assign o_int_pin = i_int_oe_n ? 1'b1 : i_int_o;
  assign o_rst_pin = i_rst_oe_n & ~i_btn;
endmodule

//--- verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_sys_rst = 1, pf = 0, cs_n = 1, oe_n = 1, g_in_n = 1, btn = 0, h_en = 0;
  rsp_pkg::rsp_events_t ev = '0;
  logic [7:0] rd_d = 8'h00, h_d = 8'h00, bus, dq_o, dq_oe_n, wr_d;
  logic int_o, int_oe_n, rst_oe_n, g_out_n, int_pin, rst_pin;
  int fails = 0, tests_run = 0, cyc = 0;
  always #2.5 i_clk = ~i_clk;
  rsp_supervisor #(.RST_HOLD_CYC(50), .CE_HOLD_CYC(20)) dut (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_pwr_fail(pf), .i_events(ev), .o_int_n_o(int_o),
    .o_int_n_oe_n(int_oe_n), .i_rst_n_i(rst_pin), .o_rst_n_o(), .o_rst_n_oe_n(rst_oe_n),
    .i_cs_n(cs_n), .i_oe_n(oe_n), .i_rd_data(rd_d), .i_data_lines_i(bus),
    .o_data_lines_o(dq_o), .o_data_lines_oe_n(dq_oe_n), .o_wr_data(wr_d),
    .i_enable_gate_in_n(g_in_n), .o_enable_gate_out_n(g_out_n));
  rsp_host_model host (.i_clk(i_clk), .i_host_en(h_en), .i_btn(btn), .i_int_o(int_o),
    .i_int_oe_n(int_oe_n), .i_rst_oe_n(rst_oe_n), .i_dev_d(dq_o), .i_dev_oe_n(dq_oe_n),
    .i_host_d(h_d), .o_bus(bus), .o_int_pin(int_pin), .o_rst_pin(rst_pin));
  // Cycle wait on the driving edge
  task automatic w(int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Boot: reset pin held through the hold time, then released
  task automatic t_boot();
    w(30); chk("rst_boot_hold", 8'h00, {7'h00, rst_pin});
    w(35); chk("rst_boot", 8'h01, {7'h00, rst_pin});
    $display("t_boot done");
  endtask
  // Each of the three i_events bits alone pulls and releases the pin
  task automatic t_int();
    for (int i = 0; i < 3; i++) begin
      ev = rsp_pkg::rsp_events_t'(3'b001 << i);
      w(2); chk("int_low", 8'h00, {7'h00, int_pin});
      ev = '0;
      w(6); chk("int_free", 8'h01, {7'h00, int_pin});
    end
    $display("t_int done");
  endtask
  // Supply loss with gate active, then recovery
  task automatic t_pf();
    g_in_n = 0;
    w(5); chk("gate_on", 8'h00, {7'h00, g_out_n});
    pf = 1;
    w(5); chk("rst_pf", 8'h00, {7'h00, rst_pin});
    chk("gate_hold", 8'h00, {7'h00, g_out_n});
    w(25); chk("gate_cut", 8'h01, {7'h00, g_out_n});
    pf = 0;
    w(40); chk("rst_hold", 8'h00, {7'h00, rst_pin});
    w(20); chk("rst_rel", 8'h01, {7'h00, rst_pin});
    g_in_n = 1;
    w(5); chk("gate_off", 8'h01, {7'h00, g_out_n});
    $display("t_pf done");
  endtask
  // Short press ignored, long press restarts reset
  task automatic t_btn();
    btn = 1; w(100); btn = 0;
    w(5); chk("btn_short", 8'h01, {7'h00, rst_pin});
    btn = 1; w(210); btn = 0;
    w(5); chk("btn_long", 8'h00, {7'h00, rst_pin});
    w(65); chk("btn_end", 8'h01, {7'h00, rst_pin});
    $display("t_btn done");
  endtask
  // Host write level, read drive, deselect during enable
  task automatic t_read();
    h_en = 1; h_d = 8'hA5; cs_n = 0;
    w(5); chk("wr_data", 8'hA5, wr_d);
    chk("no_drive", 8'hFF, dq_oe_n);
    h_en = 0; rd_d = 8'h3C; oe_n = 0;
    w(5); chk("rd_bus", 8'h3C, bus);
    cs_n = 1;
    w(5); chk("desel", 8'hFF, dq_oe_n);
    oe_n = 1;
    $display("t_read done");
  endtask
  // Hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    w(16); i_sys_rst = 0;
    t_boot();
    t_int();
    t_pf();
    t_btn();
    t_read();
    test_done();
  end
endmodule
